// *** tsg_defines.svh ***
// tsg_defines.svh - widths, field positions and depths of the trace speculation gate
`ifndef TSG_DEFINES_SVH
`define TSG_DEFINES_SVH
`define TSG_KIND_W      4
`define TSG_PAY_W       32
`define TSG_PRIV_W      2
`define TSG_ELEM_W      37
`define TSG_KIND_HI     36
`define TSG_KIND_LO     33
`define TSG_TX_BIT      32
`define TSG_PAY_HI      31
`define TSG_FIFO_DEPTH  8
`define TSG_FIFO_LVL_W  4
`define TSG_FIFO_SAFE   4'h6
`define TSG_HOLD_DEPTH  8
`define TSG_HOLD_PTR_W  3
`define TSG_HOLD_SAFE   4'h6
`define TSG_GATE_W      2
`define TSG_GATE_MAX    2'h3
`endif

// *** tsg_pkg.sv ***
// tsg_pkg.sv - element kinds and state encodings of the trace speculation gate
`default_nettype none
package tsg_pkg;
   typedef enum logic [3:0] {
      TSG_K_INSTR,
      TSG_K_COMMIT,
      TSG_K_CANCEL,
      TSG_K_TX_START,
      TSG_K_TX_COMMIT,
      TSG_K_TX_FAIL,
      TSG_K_GATE_OPEN,
      TSG_K_GATE_TAKEN,
      TSG_K_GATE_NOT
   } tsg_kind_t;

   typedef enum logic [1:0] {
      TSG_S_PASS,
      TSG_S_HOLD,
      TSG_S_DRAIN
   } tsg_state_t;
endpackage : tsg_pkg
`default_nettype wire

// *** tsg_fifo.sv ***
// tsg_fifo.sv - synchronous element FIFO with valid/ready on both sides
`default_nettype none
module tsg_fifo #(
   parameter int WIDTH = 37,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic      [AW:0]      level
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_reg;
   logic [AW:0]      rd_reg;
   wire              push = ce && in_valid && in_ready;
   wire              pop  = ce && out_valid && out_ready;

   assign level     = wr_reg - rd_reg;
   assign in_ready  = (level != DEPTH[AW:0]);
   assign out_valid = (level != '0);
   assign out_data  = mem[rd_reg[AW-1:0]];

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end
endmodule : tsg_fifo
`default_nettype wire

// *** tsg_gate.sv ***
// tsg_gate.sv - speculation gating of the trace element stream
//
// Overview of operation
// - speculative instruction elements pass to the output exactly like committed ones.
// - commit and cancel resolution elements follow the traced instructions in the stream.
// - mask instruction payload the executing privilege level could not itself read.
// - while a speculated synchronization event is unresolved, hold all younger trace except transaction failure elements.
// - not-taken synchronization event discards the held younger trace untraced.
// - while a speculated prohibited-region exit is unresolved, emit no younger trace except transaction failure elements.
// - not-taken prohibited-region exit discards the held younger trace untraced.
// - mark transactional instructions and report transaction success or failure.
// - transactions use three element kinds: start, commit, failure.
// - disable, overflow or prohibited entry inside a transaction emits a failure element.
`default_nettype none
`include "tsg_defines.svh"
module tsg_gate (
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   input  wire logic                     ce,
   input  wire logic                     in_valid,
   output logic                          in_ready,
   input  wire logic [`TSG_KIND_W-1:0]   in_kind,
   input  wire logic [`TSG_PAY_W-1:0]    in_payload,
   input  wire logic [`TSG_PRIV_W-1:0]   in_priv,
   input  wire logic [`TSG_PRIV_W-1:0]   in_data_priv,
   input  wire logic                     trace_en,
   input  wire logic                     prohibited,
   input  wire logic                     buf_ovf,
   output logic                          out_valid,
   input  wire logic                     out_ready,
   output logic      [`TSG_KIND_W-1:0]   out_kind,
   output logic                          out_tx,
   output logic      [`TSG_PAY_W-1:0]    out_payload,
   output logic                          gate_busy,
   output logic                          tx_active
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   tsg_pkg::tsg_state_t         state_reg, state_next;
   logic [`TSG_GATE_W-1:0]      gate_cnt_reg, gate_cnt_next;
   logic [`TSG_ELEM_W-1:0]      hold_mem [`TSG_HOLD_DEPTH];
   logic [`TSG_HOLD_PTR_W-1:0]  hold_wr_reg, hold_rd_reg;
   logic [`TSG_HOLD_PTR_W:0]    hold_cnt_reg, hold_cnt_next;
   logic                        tx_reg, tx_next;
   logic                        fail_pend_reg, fail_pend_next;
   logic                        in_ready_reg, in_ready_next;
   logic                        trace_en_reg, prohib_reg;
   logic                        out_valid_reg;
   logic                        gate_busy_reg;
   logic [`TSG_ELEM_W-1:0]      out_elem_reg;

   // ------------------------------------------------------------
   // input decode
   // ------------------------------------------------------------
   wire [`TSG_KIND_W-1:0] kind = in_kind;
   wire accept    = ce && in_valid && in_ready_reg;
   wire is_gate   = (kind == tsg_pkg::TSG_K_GATE_OPEN) || (kind == tsg_pkg::TSG_K_GATE_TAKEN)
                    || (kind == tsg_pkg::TSG_K_GATE_NOT);
   wire is_instr  = (kind == tsg_pkg::TSG_K_INSTR);
   wire tx_start  = accept && (kind == tsg_pkg::TSG_K_TX_START) && trace_en;
   wire tx_end    = accept && ((kind == tsg_pkg::TSG_K_TX_COMMIT)
                    || (kind == tsg_pkg::TSG_K_TX_FAIL));
   wire trace_elem = accept && !is_gate && trace_en;
   wire gate_open = accept && (kind == tsg_pkg::TSG_K_GATE_OPEN);
   wire gate_take = accept && (kind == tsg_pkg::TSG_K_GATE_TAKEN) && (gate_cnt_reg != '0);
   wire gate_not  = accept && (kind == tsg_pkg::TSG_K_GATE_NOT);

   wire priv_hide = is_instr && (in_data_priv > in_priv);
   wire [`TSG_PAY_W-1:0] pay_safe = priv_hide ? '0 : in_payload;
   wire tx_mark   = tx_reg || (kind == tsg_pkg::TSG_K_TX_START);
   wire [`TSG_ELEM_W-1:0] elem_in  = {in_kind, tx_mark, pay_safe};
   wire [`TSG_ELEM_W-1:0] elem_fail = {tsg_pkg::TSG_K_TX_FAIL, 1'b1, {`TSG_PAY_W{1'b0}}};

   // ------------------------------------------------------------
   // transaction failure causes
   // ------------------------------------------------------------
   wire en_fall   = trace_en_reg && !trace_en;
   wire pro_rise  = !prohib_reg && prohibited;
   wire fail_evt  = ce && tx_reg && (en_fall || buf_ovf || pro_rise);

   // ------------------------------------------------------------
   // FIFO feed: failure first, then release, then live input
   // ------------------------------------------------------------
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [`TSG_ELEM_W-1:0]    fifo_out_data;
   wire [`TSG_FIFO_LVL_W-1:0] fifo_level;
   wire draining  = (state_reg == tsg_pkg::TSG_S_DRAIN) && (hold_cnt_reg != '0)
                    && !fail_pend_reg;
   wire pass_live = trace_elem && (state_reg == tsg_pkg::TSG_S_PASS);
   wire hold_live = trace_elem && (state_reg == tsg_pkg::TSG_S_HOLD);
   wire fifo_in_valid = fail_pend_reg || draining || pass_live;
   wire [`TSG_ELEM_W-1:0] fifo_in_data = fail_pend_reg ? elem_fail :
                                         draining ? hold_mem[hold_rd_reg] : elem_in;
   wire fail_push = fail_pend_reg && fifo_in_ready && ce;
   wire drain_pop = draining && fifo_in_ready && ce;
   wire out_pop   = fifo_out_valid && (!out_valid_reg || out_ready);

   tsg_fifo #(
      .WIDTH (`TSG_ELEM_W),
      .DEPTH (`TSG_FIFO_DEPTH),
      .AW    (`TSG_HOLD_PTR_W)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (out_pop),
      .out_data  (fifo_out_data),
      .level     (fifo_level)
   );

   // ------------------------------------------------------------
   // gate sequencing
   // ------------------------------------------------------------
   always_comb begin
      state_next    = state_reg;
      gate_cnt_next = gate_cnt_reg;
      hold_cnt_next = hold_cnt_reg + {3'h0, hold_live} - {3'h0, drain_pop};
      case (state_reg)
         tsg_pkg::TSG_S_PASS: begin
            if (gate_open) begin
               gate_cnt_next = 2'h1;
               state_next    = tsg_pkg::TSG_S_HOLD;
            end
         end
         tsg_pkg::TSG_S_HOLD: begin
            if (gate_not) begin
               gate_cnt_next = '0;
               hold_cnt_next = '0;
               state_next    = tsg_pkg::TSG_S_PASS;
            end else if (gate_open && gate_cnt_reg != `TSG_GATE_MAX) begin
               gate_cnt_next = gate_cnt_reg + 2'h1;
            end else if (gate_take) begin
               gate_cnt_next = gate_cnt_reg - 2'h1;
               if (gate_cnt_reg == 2'h1) begin
                  state_next = tsg_pkg::TSG_S_DRAIN;
               end
            end
         end
         tsg_pkg::TSG_S_DRAIN: begin
            if (hold_cnt_next == '0) begin
               state_next = tsg_pkg::TSG_S_PASS;
            end
         end
         default: begin
            state_next = tsg_pkg::TSG_S_PASS;
         end
      endcase
   end

   assign tx_next        = tx_start || (tx_reg && !tx_end && !fail_evt);
   assign fail_pend_next = fail_evt || (fail_pend_reg && !fail_push);
   assign in_ready_next  = (state_next != tsg_pkg::TSG_S_DRAIN) && !fail_pend_next
                           && (fifo_level < `TSG_FIFO_SAFE) && (hold_cnt_next < `TSG_HOLD_SAFE);

   always_ff @(posedge core_clk) begin
      if (ce && hold_live) begin
         hold_mem[hold_wr_reg] <= elem_in;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= tsg_pkg::TSG_S_PASS;
         gate_cnt_reg  <= '0;
         hold_wr_reg   <= '0;
         hold_rd_reg   <= '0;
         hold_cnt_reg  <= '0;
         tx_reg        <= 1'b0;
         fail_pend_reg <= 1'b0;
         in_ready_reg  <= 1'b0;
         trace_en_reg  <= 1'b0;
         prohib_reg    <= 1'b0;
         gate_busy_reg <= 1'b0;
      end else if (ce) begin
         state_reg     <= state_next;
         gate_cnt_reg  <= gate_cnt_next;
         hold_cnt_reg  <= hold_cnt_next;
         hold_wr_reg   <= (gate_not) ? '0 : hold_wr_reg + {2'h0, hold_live};
         hold_rd_reg   <= (gate_not) ? '0 : hold_rd_reg + {2'h0, drain_pop};
         tx_reg        <= tx_next;
         fail_pend_reg <= fail_pend_next;
         in_ready_reg  <= in_ready_next;
         trace_en_reg  <= trace_en;
         prohib_reg    <= prohibited;
         gate_busy_reg <= (state_next == tsg_pkg::TSG_S_HOLD);
      end
   end

   // ------------------------------------------------------------
   // output register stage
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid_reg <= 1'b0;
         out_elem_reg  <= '0;
      end else if (ce && (!out_valid_reg || out_ready)) begin
         out_valid_reg <= fifo_out_valid;
         out_elem_reg  <= fifo_out_data;
      end
   end

   assign in_ready    = in_ready_reg;
   assign out_valid   = out_valid_reg;
   assign out_kind    = out_elem_reg[`TSG_KIND_HI:`TSG_KIND_LO];
   assign out_tx      = out_elem_reg[`TSG_TX_BIT];
   assign out_payload = out_elem_reg[`TSG_PAY_HI:0];
   assign gate_busy   = gate_busy_reg;
   assign tx_active   = tx_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_open_starts_hold: assert property (gate_open && state_reg == tsg_pkg::TSG_S_PASS
      |=> gate_busy && gate_cnt_reg == 2'h1) else $error("gate open did not hold");
   a_hold_blocks_live: assert property (state_reg == tsg_pkg::TSG_S_HOLD
      |-> !fifo_in_valid || fail_pend_reg) else $error("trace leaked while gated");
   a_not_taken_flush: assert property (gate_not && state_reg == tsg_pkg::TSG_S_HOLD
      |=> hold_cnt_reg == '0 && state_reg == tsg_pkg::TSG_S_PASS && !draining)
      else $error("not-taken gate kept held trace");
   a_not_taken_exit: assert property (gate_not ##1 !accept
      |-> !draining) else $error("flushed trace was released");
   a_taken_release: assert property (gate_take && gate_cnt_reg == 2'h1
      && hold_cnt_reg != '0 |=> state_reg == tsg_pkg::TSG_S_DRAIN)
      else $error("taken gate did not release");
   a_live_passes: assert property (pass_live && !fail_pend_reg
      |-> fifo_in_valid && fifo_in_ready && fifo_in_data == elem_in)
      else $error("live element not traced");
   a_resolve_passes: assert property (pass_live && !is_instr
      |-> fifo_in_valid && fifo_in_ready
      && fifo_in_data[`TSG_KIND_HI:`TSG_KIND_LO] == in_kind)
      else $error("resolution element altered");
   a_priv_masked: assert property (pass_live && priv_hide
      |-> fifo_in_data[`TSG_PAY_HI:0] == '0) else $error("privileged payload leaked");
   a_tx_marked: assert property (tx_start ##1 ce && pass_live && is_instr
      |-> fifo_in_data[`TSG_TX_BIT]) else $error("transactional instruction unmarked");
   a_fail_emitted: assert property (fail_evt |=> fail_pend_reg ##[0:20] fail_push
      ) else $error("transaction failure not emitted");
   a_tx_closed: assert property (tx_end && !tx_start |=> !tx_reg
      ) else $error("transaction state not closed");
endmodule : tsg_gate
`default_nettype wire

// *** tsg_sink_model.sv ***
// tsg_sink_model.sv - trace analyzer model that accepts and logs output elements
`default_nettype none
`include "tsg_defines.svh"
module tsg_sink_model (
   input  wire logic                   core_clk,
   input  wire logic                   stall,
   input  wire logic                   slow,
   input  wire logic                   out_valid,
   output logic                        out_ready,
   input  wire logic [`TSG_KIND_W-1:0] out_kind,
   input  wire logic                   out_tx,
   input  wire logic [`TSG_PAY_W-1:0]  out_payload
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [`TSG_ELEM_W-1:0] got[$];
   logic                   phase;
   initial begin
      out_ready = 1'b0;
      phase     = 1'b0;
   end
   // ready moves only after the falling edge; slow mode takes every other cycle
   always @(negedge core_clk) begin
      phase     <= ~phase;
      out_ready <= !stall && (!slow || phase);
   end
   always @(posedge core_clk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         got.push_back({out_kind, out_tx, out_payload});
      end
   end
endmodule : tsg_sink_model
`default_nettype wire

// *** tb.sv ***
// tb.sv - self-checking testbench of the trace speculation gate
`default_nettype none
`include "tsg_defines.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    core_clk, rst_n, ce, in_valid, in_ready, trace_en, prohibited;
   logic                    buf_ovf, out_valid, out_ready, out_tx, gate_busy, tx_active;
   logic                    stall, slow;
   logic [`TSG_KIND_W-1:0]  in_kind, out_kind;
   logic [`TSG_PAY_W-1:0]   in_payload, out_payload;
   logic [`TSG_PRIV_W-1:0]  in_priv, in_data_priv;
   logic [`TSG_ELEM_W-1:0]  exp_q[$];
   int                      miscompares, cmp_count;

   tsg_gate dut_u (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .in_valid(in_valid),
      .in_ready(in_ready), .in_kind(in_kind), .in_payload(in_payload), .in_priv(in_priv),
      .in_data_priv(in_data_priv), .trace_en(trace_en), .prohibited(prohibited),
      .buf_ovf(buf_ovf), .out_valid(out_valid), .out_ready(out_ready), .out_kind(out_kind),
      .out_tx(out_tx), .out_payload(out_payload), .gate_busy(gate_busy),
      .tx_active(tx_active));
   tsg_sink_model sink_u (.core_clk(core_clk), .stall(stall), .slow(slow),
      .out_valid(out_valid), .out_ready(out_ready), .out_kind(out_kind), .out_tx(out_tx),
      .out_payload(out_payload));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic check(input string what, input logic [`TSG_ELEM_W-1:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish

   // offer one element and hold it until the edge that takes it
   task automatic send(input tsg_pkg::tsg_kind_t k, input logic [31:0] p,
                       input logic [1:0] pr = 2'h0, input logic [1:0] dp = 2'h0);
      int n;
      @(negedge core_clk);
      in_valid = 1'b1;
      in_kind = k;
      in_payload = p;
      in_priv = pr;
      in_data_priv = dp;
      n = 0;
      while (in_ready !== 1'b1 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 300) check("input taken", 37'(in_ready), 37'h1);
      @(posedge core_clk);
   endtask : send

   task automatic idle(input int cyc);
      @(negedge core_clk);
      in_valid = 1'b0;
      repeat (cyc) @(negedge core_clk);
   endtask : idle

   task automatic expect_el(input tsg_pkg::tsg_kind_t k, input logic tx, input logic [31:0] p);
      exp_q.push_back({k, tx, p});
   endtask : expect_el

   // wait for the expected count, then compare the stream in order
   task automatic drain;
      int n;
      n = 0;
      while (sink_u.got.size() < exp_q.size() && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      repeat (4) @(negedge core_clk);
      check("element count", 37'(sink_u.got.size()), 37'(exp_q.size()));
      foreach (exp_q[i]) begin
         if (i < sink_u.got.size()) check("element", sink_u.got[i], exp_q[i]);
      end
      sink_u.got.delete();
      exp_q.delete();
   endtask : drain

   task automatic s_plain;
      send(tsg_pkg::TSG_K_INSTR, 32'h0000_1000, 2'h1, 2'h1);
      send(tsg_pkg::TSG_K_INSTR, 32'h0000_2000, 2'h1, 2'h2);
      send(tsg_pkg::TSG_K_COMMIT, 32'h0000_0001);
      send(tsg_pkg::TSG_K_CANCEL, 32'h0000_0001);
      idle(1);
      expect_el(tsg_pkg::TSG_K_INSTR, 1'b0, 32'h0000_1000);
      expect_el(tsg_pkg::TSG_K_INSTR, 1'b0, 32'h0000_0000);
      expect_el(tsg_pkg::TSG_K_COMMIT, 1'b0, 32'h0000_0001);
      expect_el(tsg_pkg::TSG_K_CANCEL, 1'b0, 32'h0000_0001);
      drain();
   endtask : s_plain

   // gated trace held, then released on taken or flushed on not taken
   task automatic s_gate(input logic taken);
      send(tsg_pkg::TSG_K_GATE_OPEN, 32'h0000_0000);
      send(tsg_pkg::TSG_K_INSTR, 32'h0000_3000);
      send(tsg_pkg::TSG_K_COMMIT, 32'h0000_0001);
      idle(10);
      check("gate busy", 37'(gate_busy), 37'h1);
      check("held count", 37'(sink_u.got.size()), 37'h0);
      send(taken ? tsg_pkg::TSG_K_GATE_TAKEN : tsg_pkg::TSG_K_GATE_NOT, 32'h0000_0000);
      idle(1);
      if (taken) begin
         expect_el(tsg_pkg::TSG_K_INSTR, 1'b0, 32'h0000_3000);
         expect_el(tsg_pkg::TSG_K_COMMIT, 1'b0, 32'h0000_0001);
      end
      drain();
      check("gate idle", 37'(gate_busy), 37'h0);
   endtask : s_gate

   task automatic s_tx(input int cause);
      send(tsg_pkg::TSG_K_TX_START, 32'h0000_0000);
      send(tsg_pkg::TSG_K_INSTR, 32'h0000_4000);
      idle(3);
      check("tx active", 37'(tx_active), 37'h1);
      expect_el(tsg_pkg::TSG_K_TX_START, 1'b1, 32'h0000_0000);
      expect_el(tsg_pkg::TSG_K_INSTR, 1'b1, 32'h0000_4000);
      if (cause == 0) begin
         send(tsg_pkg::TSG_K_TX_COMMIT, 32'h0000_0000);
         idle(1);
         expect_el(tsg_pkg::TSG_K_TX_COMMIT, 1'b1, 32'h0000_0000);
      end else if (cause == 4) begin
         send(tsg_pkg::TSG_K_TX_FAIL, 32'h0000_0000);
         idle(1);
         expect_el(tsg_pkg::TSG_K_TX_FAIL, 1'b1, 32'h0000_0000);
      end else begin
         @(negedge core_clk);
         if (cause == 1) trace_en = 1'b0;
         if (cause == 2) buf_ovf = 1'b1;
         if (cause == 3) prohibited = 1'b1;
         @(negedge core_clk);
         buf_ovf = 1'b0;
         expect_el(tsg_pkg::TSG_K_TX_FAIL, 1'b1, 32'h0000_0000);
      end
      drain();
      check("tx closed", 37'(tx_active), 37'h0);
      trace_en = 1'b1;
      prohibited = 1'b0;
   endtask : s_tx

   // analyzer stalls until the queue refuses, then takes everything in order
   task automatic s_fill;
      stall = 1'b1;
      fork
         begin
            repeat (40) @(negedge core_clk);
            check("refused when full", 37'(in_ready), 37'h0);
            check("nothing out", 37'(sink_u.got.size()), 37'h0);
            stall = 1'b0;
         end
         for (int i = 0; i < 12; i++) send(tsg_pkg::TSG_K_INSTR, 32'(i));
      join
      idle(1);
      for (int i = 0; i < 12; i++) expect_el(tsg_pkg::TSG_K_INSTR, 1'b0, 32'(i));
      drain();
   endtask : s_fill

   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      in_valid = 1'b0;
      in_kind = 4'h0;
      in_payload = 32'h0;
      in_priv = 2'h0;
      in_data_priv = 2'h0;
      trace_en = 1'b1;
      prohibited = 1'b0;
      buf_ovf = 1'b0;
      stall = 1'b0;
      slow = 1'b0;
      miscompares = 0;
      cmp_count = 0;
      repeat (5) @(negedge core_clk);
      rst_n = 1'b1;
      idle(2);
      s_plain();
      s_gate(1'b1);
      s_gate(1'b0);
      slow = 1'b1;
      s_gate(1'b1);
      for (int c = 0; c < 5; c++) s_tx(c);
      slow = 1'b0;
      s_fill();
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
